// file: design/module_setup_command_registers.v
// Setup, output, timeout and command registers of the expansion module
// Notes on behaviour
// - Setup bit 5 mirrors module registers at 0x300
// - Setup bit 1 set disables error reaction
// - Setup bit 0: passive or velocity zero
// - Output register bits drive output pins directly
// - Absent output pin in variant has no effect
// - Timeout value zero disables inactivity supervision
// - Timeout counts 100 ms steps, bits 0-15
// - Command register write-only, writes execute commands
// - Codes 0 nop, 1 reset, 16 save module
// - Code 257 resets motor and module together
// - Code 272 saves motor then resyncs link
// - Motor-only reset; synchronized reset preferred
// - Motor save then reset; synchronized save preferred
// - Fast command clears motor error register bits
// - Module parameters saved only by save command
// - 32-bit words as two halves, low first
`timescale 1ns/1ps
`default_nettype none
`include "module_setup_defs.vh"

module module_setup_command_registers #(
  parameter SECOND_OUTPUT_FITTED = 1,
  parameter TIMEOUT_STEP_CYCLES = `TIMEOUT_STEP_CYCLES
) (
  input wire sys_clk,
  input wire rst_n,
  input wire requestSeen,
  input wire [15:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regWdata,
  input wire ethLinkError,
  output reg [15:0] regRdata,
  output reg regRvalid,
  output reg regHit,
  output reg firstOutputPin,
  output reg secondOutputPin,
  output reg motorPassiveReq,
  output reg motorVelZeroReq,
  output reg moduleResetReq,
  output reg moduleSaveReq,
  output reg motorResetReq,
  output reg motorSaveReq,
  output reg linkResyncReq,
  output reg motorErrClearReq,
  output reg [31:0] setupValue,
  output reg [15:0] timeoutValue
);

  // ==========================================
  // Address decode
  // Result is {hit, word index, upper half}
  function [7:0] decodeAddr;
    input [15:0] addr;
    input mirrorOn;
    reg [15:0] offs;
    begin
      decodeAddr = 8'h00;
      if (addr >= `MODULE_BASE_ADDR && addr < `MODULE_BASE_ADDR + {8'h00, `MODULE_SPAN_WORDS, 1'b0})
      begin
        offs = addr - `MODULE_BASE_ADDR;
        decodeAddr = {1'b1, offs[6:0]};
      end
      else if (mirrorOn && addr >= `MIRROR_BASE_ADDR
               && addr < `MIRROR_BASE_ADDR + {8'h00, `MODULE_SPAN_WORDS, 1'b0})
      begin
        offs = addr - `MIRROR_BASE_ADDR;
        decodeAddr = {1'b1, offs[6:0]};
      end
    end
  endfunction

  // ==========================================
  // Registers
  reg [31:0] setup_reg;
  reg [31:0] outputs_reg;
  reg [15:0] timeout_reg;
  reg [15:0] wrLow_reg;
  reg [15:0] rdHigh_reg;
  reg errSync1_reg;
  reg errSync2_reg;
  reg errPrev_reg;
  reg [31:0] cmd_next;
  reg cmdStrobe;
  wire [7:0] dec;
  wire hit;
  wire [5:0] idx;
  wire upper;
  wire timeoutExpired;
  wire linkErrEvent;
  wire reactEvent;
  wire [31:0] rdWord;

  assign dec = decodeAddr(regAddr, setup_reg[`SETUP_MIRROR_BIT]);
  assign hit = dec[7];
  assign idx = dec[6:1];
  assign upper = dec[0];

  // ==========================================
  // Register read value
  function [31:0] readWord;
    input [5:0] i;
    input [31:0] s;
    input [31:0] o;
    input [15:0] t;
    begin
      case (i)
        `IDX_SETUP: readWord = s;
        `IDX_OUTPUTS: readWord = o;
        `IDX_TIMEOUT: readWord = {16'h0000, t};
        // Command word is never stored, so it reads as zero
        default: readWord = 32'h00000000;
      endcase
    end
  endfunction

  assign rdWord = readWord(idx, setup_reg, outputs_reg, timeout_reg);

  // ==========================================
  // Half-word pairing and register writes
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      setup_reg <= `SETUP_RESET;
      outputs_reg <= `OUTPUTS_RESET;
      timeout_reg <= `TIMEOUT_RESET;
      wrLow_reg <= 16'h0000;
      rdHigh_reg <= 16'h0000;
      regRdata <= 16'h0000;
      regRvalid <= 1'b0;
      regHit <= 1'b0;
    end
    else
    begin
      regRvalid <= 1'b0;
      regHit <= 1'b0;
      if (regWrite && hit)
      begin
        regHit <= 1'b1;
        if (!upper)
        begin
          // Low half waits until its high half arrives
          wrLow_reg <= regWdata;
        end
        else
        begin
          case (idx)
            `IDX_SETUP: setup_reg <= {regWdata, wrLow_reg} & `SETUP_USED_MASK;
            `IDX_OUTPUTS: outputs_reg <= {regWdata, wrLow_reg} & `OUTPUTS_USED_MASK;
            `IDX_TIMEOUT: timeout_reg <= wrLow_reg;
            default: timeout_reg <= timeout_reg;
          endcase
        end
      end
      else if (regRead && !regWrite)
      begin
        regRvalid <= 1'b1;
        regHit <= hit;
        if (!hit)
        begin
          regRdata <= 16'h0000;
        end
        else if (!upper)
        begin
          // Upper half is captured with the lower so the pair is coherent
          regRdata <= rdWord[15:0];
          rdHigh_reg <= rdWord[31:16];
        end
        else
        begin
          regRdata <= rdHigh_reg;
        end
      end
    end
  end

  // ==========================================
  // Command execution
  always @*
  begin
    cmd_next = {regWdata, wrLow_reg};
    cmdStrobe = regWrite && hit && upper && (idx == `IDX_COMMAND);
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      moduleResetReq <= 1'b0;
      moduleSaveReq <= 1'b0;
      motorResetReq <= 1'b0;
      motorSaveReq <= 1'b0;
      linkResyncReq <= 1'b0;
      motorErrClearReq <= 1'b0;
    end
    else
    begin
      moduleResetReq <= 1'b0;
      moduleSaveReq <= 1'b0;
      motorResetReq <= 1'b0;
      motorSaveReq <= 1'b0;
      linkResyncReq <= 1'b0;
      motorErrClearReq <= 1'b0;
      if (cmdStrobe)
      begin
        case (cmd_next)
          `CMD_NOP: moduleResetReq <= 1'b0;
          `CMD_MODULE_RESET: moduleResetReq <= 1'b1;
          // Flash copy changes only here, never on a register write
          `CMD_MODULE_SAVE: moduleSaveReq <= 1'b1;
          `CMD_SYNC_RESET:
          begin
            moduleResetReq <= 1'b1;
            motorResetReq <= 1'b1;
          end
          `CMD_SYNC_SAVE:
          begin
            // Motor side sequences the resync after its save completes
            motorSaveReq <= 1'b1;
            linkResyncReq <= 1'b1;
          end
          `CMD_MOTOR_RESET: motorResetReq <= 1'b1;
          `CMD_MOTOR_SAVE_RESET:
          begin
            motorSaveReq <= 1'b1;
            motorResetReq <= 1'b1;
          end
          `CMD_MOTOR_CLEAR_ERR: motorErrClearReq <= 1'b1;
          default: motorErrClearReq <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================
  // Communication error reaction
  inactivity_timer #(
    .STEP_CYCLES(TIMEOUT_STEP_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .timeoutSteps(timeout_reg),
    .requestSeen(requestSeen),
    .expired(timeoutExpired)
  );

  assign linkErrEvent = errSync2_reg && !errPrev_reg;
  assign reactEvent = (linkErrEvent || timeoutExpired) && !setup_reg[`SETUP_DISABLE_BIT];

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      errSync1_reg <= 1'b0;
      errSync2_reg <= 1'b0;
      errPrev_reg <= 1'b0;
      motorPassiveReq <= 1'b0;
      motorVelZeroReq <= 1'b0;
    end
    else
    begin
      // Error level comes from another domain
      errSync1_reg <= ethLinkError;
      errSync2_reg <= errSync1_reg;
      errPrev_reg <= errSync2_reg;
      motorPassiveReq <= reactEvent && !setup_reg[`SETUP_REACT_BIT];
      motorVelZeroReq <= reactEvent && setup_reg[`SETUP_REACT_BIT];
    end
  end

  // ==========================================
  // Output pins and visible settings
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      firstOutputPin <= 1'b0;
      secondOutputPin <= 1'b0;
      setupValue <= `SETUP_RESET;
      timeoutValue <= `TIMEOUT_RESET;
    end
    else
    begin
      firstOutputPin <= outputs_reg[0];
      // Bit still stores and reads back, but a missing pin stays low
      secondOutputPin <= outputs_reg[1] && (SECOND_OUTPUT_FITTED != 0);
      setupValue <= setup_reg;
      timeoutValue <= timeout_reg;
    end
  end

endmodule

`default_nettype wire

// file: design/module_setup_defs.vh
// Constants for the module setup and command register bank
`ifndef MODULE_SETUP_DEFS_VH
`define MODULE_SETUP_DEFS_VH

// ==========================================
// Address map
`define MODULE_BASE_ADDR 16'h8000
`define MIRROR_BASE_ADDR 16'h0300
`define MODULE_SPAN_WORDS 7'd64
`define IDX_SETUP 6'd6
`define IDX_OUTPUTS 6'd7
`define IDX_TIMEOUT 6'd10
`define IDX_COMMAND 6'd15

// ==========================================
// Field positions and reset values
`define SETUP_REACT_BIT 0
`define SETUP_DISABLE_BIT 1
`define SETUP_MIRROR_BIT 5
`define SETUP_USED_MASK 32'h00000023
`define OUTPUTS_USED_MASK 32'h00000003
`define TIMEOUT_USED_MASK 32'h0000ffff
`define SETUP_RESET 32'h00000000
`define OUTPUTS_RESET 32'h00000000
`define TIMEOUT_RESET 16'h0000

// ==========================================
// Command codes
`define CMD_NOP 32'h00000000
`define CMD_MODULE_RESET 32'h00000001
`define CMD_MODULE_SAVE 32'h00000010
`define CMD_SYNC_RESET 32'h00000101
`define CMD_SYNC_SAVE 32'h00000110
`define CMD_MOTOR_RESET 32'h80000001
`define CMD_MOTOR_SAVE_RESET 32'h80000002
`define CMD_MOTOR_CLEAR_ERR 32'h800000e0

// ==========================================
// Timing
`define CLK_PERIOD_NS 5
`define TIMEOUT_STEP_NS 100000000
`define TIMEOUT_STEP_CYCLES (`TIMEOUT_STEP_NS / `CLK_PERIOD_NS)

`endif

// file: design/inactivity_timer.v
// Request inactivity supervision counting in fixed steps
`timescale 1ns/1ps
`default_nettype none

module inactivity_timer #(
  parameter STEP_CYCLES = 20000000
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [15:0] timeoutSteps,
  input wire requestSeen,
  output reg expired
);

  // ==========================================
  // Step prescaler and step counter
  reg [24:0] preReg;
  reg [15:0] stepReg;
  reg armedReg;
  wire stepDone;

  assign stepDone = (preReg == STEP_CYCLES[24:0] - 25'd1);

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      preReg <= 25'd0;
      stepReg <= 16'h0000;
      armedReg <= 1'b1;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (timeoutSteps == 16'h0000 || requestSeen)
      begin
        // Zero value turns supervision off; any request restarts it
        preReg <= 25'd0;
        stepReg <= 16'h0000;
        armedReg <= 1'b1;
      end
      else if (armedReg)
      begin
        if (stepDone)
        begin
          preReg <= 25'd0;
          if (stepReg + 16'h0001 >= timeoutSteps)
          begin
            // One reaction per silence; rearmed by the next request
            expired <= 1'b1;
            armedReg <= 1'b0;
            stepReg <= 16'h0000;
          end
          else
          begin
            stepReg <= stepReg + 16'h0001;
          end
        end
        else
        begin
          preReg <= preReg + 25'd1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/module_setup_command_registers_properties.sv
// Port assertions for the setup and command register bank
`timescale 1ns/1ps
`default_nettype none
module module_setup_command_registers_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic regRvalid,
  input wire logic firstOutputPin,
  input wire logic secondOutputPin,
  input wire logic motorPassiveReq,
  input wire logic motorVelZeroReq,
  input wire logic moduleResetReq,
  input wire logic moduleSaveReq,
  input wire logic motorResetReq,
  input wire logic motorSaveReq,
  input wire logic linkResyncReq,
  input wire logic motorErrClearReq,
  input wire logic [31:0] setupValue
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Register access and commands
  a_read_answer: assert property (regRead && !regWrite |=> regRvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (regRvalid |-> $past(regRead))
    else $error("read answer without request");
  a_pins_by_write: assert property ($changed({firstOutputPin, secondOutputPin}) |-> $past(regWrite, 2))
    else $error("output pin moved without write");
  a_cmd_after_write: assert property ((moduleResetReq || moduleSaveReq || motorResetReq || motorSaveReq
    || linkResyncReq || motorErrClearReq) |-> $past(regWrite)) else $error("command without write");
  a_resync_save: assert property (linkResyncReq |-> motorSaveReq && !motorResetReq)
    else $error("resync without motor save");
  a_clear_alone: assert property (motorErrClearReq |-> !(moduleResetReq || motorResetReq || motorSaveReq))
    else $error("error clear mixed with other command");
  a_save_only: assert property (moduleSaveReq |-> !moduleResetReq && !motorSaveReq)
    else $error("module save mixed with other command");
  // Setup lags the internal register, so only a long-stable setup is trusted
  a_react_off: assert property (setupValue[1] && $past(setupValue[1], 6) |-> !(motorPassiveReq || motorVelZeroReq))
    else $error("reaction while disabled");
  a_react_kind: assert property ((motorPassiveReq || motorVelZeroReq) && setupValue[0] == $past(setupValue[0], 6)
    |-> motorVelZeroReq == setupValue[0] && motorPassiveReq != setupValue[0]) else $error("wrong reaction kind");
endmodule
bind module_setup_command_registers module_setup_command_registers_properties i_props (.*);
`default_nettype wire

// file: tb/modbus_client_model.sv
// Fieldbus client model issuing 16-bit register requests
`timescale 1ns/1ps
`default_nettype none
module modbus_client_model (
  input wire logic sys_clk,
  input wire logic [15:0] regRdata,
  input wire logic regHit,
  output logic [15:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWdata,
  output logic requestSeen
);
  initial
  begin
    regAddr = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
    requestSeen = 1'b0;
  end
  // ==========================================
  // Word transfers, low half first
  task automatic wr32(input logic [15:0] base, input logic [5:0] idx, input logic [31:0] val);
    // Idle edge first, so back-to-back calls never re-raise a strobe in one step
    @(posedge sys_clk);
    #1;
    regWrite = 1'b1;
    requestSeen = 1'b1;
    regAddr = base + {idx, 1'b0};
    regWdata = val[15:0];
    @(posedge sys_clk);
    #1;
    requestSeen = 1'b0;
    regAddr = regAddr + 16'h0001;
    regWdata = val[31:16];
    @(posedge sys_clk);
    #1;
    regWrite = 1'b0;
    // Released bus shows junk, not the last value
    regWdata = ~regWdata;
    regAddr = ~regAddr;
  endtask
  task automatic rd32(input logic [15:0] base, input logic [5:0] idx, output logic [31:0] val, output logic hit);
    @(posedge sys_clk);
    #1;
    regRead = 1'b1;
    requestSeen = 1'b1;
    regAddr = base + {idx, 1'b0};
    @(posedge sys_clk);
    #1;
    // Low half stands from the low-read edge until the high-read edge
    val[15:0] = regRdata;
    hit = regHit;
    requestSeen = 1'b0;
    regAddr = regAddr + 16'h0001;
    @(posedge sys_clk);
    #1;
    val[31:16] = regRdata;
    regRead = 1'b0;
    regAddr = ~regAddr;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_module_setup_command_registers.sv
// Self-checking bench for the setup and command register bank
`timescale 1ns/1ps
`default_nettype none
module tb_module_setup_command_registers;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ethLinkError = 1'b0;
  logic requestSeen, regWrite, regRead, regRvalid, regHit, firstOutputPin, secondOutputPin, hit;
  logic motorPassiveReq, motorVelZeroReq, moduleResetReq, moduleSaveReq, motorResetReq, motorSaveReq;
  logic linkResyncReq, motorErrClearReq;
  logic [15:0] regAddr, regWdata, regRdata, timeoutValue;
  logic [31:0] setupValue, rv;
  int nMismatch = 0;
  int numChecks = 0;
  int cycles = 0;
  int nPassive = 0;
  int nVel = 0;
  int i;
  logic [31:0] cmdCode [9] = '{32'h0, 32'h1, 32'h10, 32'h101, 32'h110, 32'h80000001, 32'h80000002,
    32'h800000e0, 32'h00010001};
  logic [5:0] cmdExp [9] = '{6'h00, 6'h20, 6'h10, 6'h28, 6'h06, 6'h08, 6'h0c, 6'h01, 6'h00};
  wire [5:0] cmdPulses = {moduleResetReq, moduleSaveReq, motorResetReq, motorSaveReq, linkResyncReq, motorErrClearReq};
  module_setup_command_registers #(.TIMEOUT_STEP_CYCLES(10)) i_dut (.*);
  modbus_client_model i_client (.*);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    nPassive += motorPassiveReq;
    nVel += motorVelZeroReq;
    if (cycles == 3000)
    begin
      nMismatch++;
      tally_and_finish;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic waitCycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ==========================================
  // Test sequence
  initial
  begin
    waitCycles(5);
    rst_n = 1'b1;
    i_client.rd32(16'h8000, 6'h06, rv, hit);
    check({hit, rv[30:0]}, 32'h80000000);
    i_client.wr32(16'h8000, 6'h07, 32'hffffffff);
    waitCycles(2);
    check({secondOutputPin, firstOutputPin}, 2'b11);
    i_client.rd32(16'h8000, 6'h07, rv, hit);
    check(rv, 32'h3);
    i_client.wr32(16'h8000, 6'h07, 32'h2);
    waitCycles(2);
    check({secondOutputPin, firstOutputPin}, 2'b10);
    for (i = 0; i < 9; i++)
    begin
      i_client.wr32(16'h8000, 6'h0f, cmdCode[i]);
      check(cmdPulses, cmdExp[i]);
    end
    i_client.rd32(16'h8000, 6'h0f, rv, hit);
    check(rv, 32'h0);
    i_client.rd32(16'h0300, 6'h07, rv, hit);
    check({hit, rv[30:0]}, 32'h0);
    i_client.wr32(16'h8000, 6'h06, 32'h20);
    waitCycles(1);
    i_client.wr32(16'h0300, 6'h07, 32'h1);
    i_client.rd32(16'h8000, 6'h07, rv, hit);
    check(rv, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      i_client.wr32(16'h8000, 6'h06, i);
      waitCycles(2);
      check(setupValue, i);
      nPassive = 0;
      nVel = 0;
      ethLinkError = 1'b1;
      waitCycles(10);
      ethLinkError = 1'b0;
      check(nPassive, i == 0);
      check(nVel, i == 1);
      waitCycles(4);
    end
    i_client.wr32(16'h8000, 6'h06, 32'h0);
    i_client.wr32(16'h8000, 6'h0a, 32'hffff0003);
    nPassive = 0;
    i_client.rd32(16'h8000, 6'h0a, rv, hit);
    check(rv, 32'h3);
    check(timeoutValue, 32'h3);
    // Last request edge plus three steps of ten cycles, pulse counted two edges later
    waitCycles(29);
    check(nPassive, 0);
    waitCycles(3);
    check(nPassive, 1);
    waitCycles(40);
    check(nPassive, 1);
    i_client.wr32(16'h8000, 6'h0a, 32'h0);
    waitCycles(80);
    check(nPassive, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
